// ---- hdl/imba_pkg.sv ----
// Shared constants and types for the I2C master arbitration block.
// Assumes one clock domain; bus pins arrive unsynchronised.
package imba_pkg;

    localparam int BAUD_W = 8;
    localparam int SEQ_W  = 4;
    localparam int BIT_W  = 4;
    localparam int SYNC_STAGES = 2;

    // Sequence request bit positions
    localparam int SEQ_START   = 0;
    localparam int SEQ_RESTART = 1;
    localparam int SEQ_STOP    = 2;
    localparam int SEQ_ACK     = 3;

    // Bit counter: data bits 7..0 then the acknowledge slot
    localparam logic [BIT_W-1:0] BIT_FIRST = 4'h7;
    localparam logic [BIT_W-1:0] BIT_ACK   = 4'h8;
    localparam logic [BIT_W-1:0] BIT_RESET = 4'h0;

    localparam logic [BAUD_W-1:0] BAUD_RESET = 8'h00;
    localparam logic [SEQ_W-1:0]  SEQ_RESET  = 4'h0;
    localparam logic [7:0]        BYTE_RESET = 8'h00;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00000,
        ST_CNT1  = 5'b00001,
        ST_CNT2  = 5'b00010,
        RS_CNT0  = 5'b00011,
        RS_WSCL  = 5'b00100,
        RS_CNT1  = 5'b00101,
        RS_CNT2  = 5'b00110,
        SP_WSDA  = 5'b00111,
        SP_CNT0  = 5'b01000,
        SP_WSCL  = 5'b01001,
        SP_CNT1  = 5'b01010,
        SP_CNT2  = 5'b01011,
        AK_CNT0  = 5'b01100,
        AK_WSCL  = 5'b01101,
        AK_CNT1  = 5'b01110,
        TX_LOW   = 5'b01111,
        TX_WSCL  = 5'b10000,
        TX_HIGH  = 5'b10001
    } imba_state_type;

endpackage

// ---- hdl/imba_baud_if.sv ----
// Link between the sequencer and its baud counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface imba_baud_if;
    import imba_pkg::*;
    logic [BAUD_W-1:0] reload_value;
    logic              load;
    logic              expired;

    modport ctrl (output reload_value, output load, input expired);
    modport cnt  (input reload_value, input load, output expired);
endinterface
`default_nettype wire

// ---- hdl/imba_baud_counter.sv ----
// Down counter timing each half period of the serial clock.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/100ps
`default_nettype none
module imba_baud_counter (
    input  wire logic  mclk,
    input  wire logic  resetn,
    imba_baud_if.cnt   baud
);
    import imba_pkg::*;

    logic [BAUD_W-1:0] count;
    logic [BAUD_W-1:0] next_count;
    logic              active;
    logic              next_active;

    assign baud.expired = active && (count == BAUD_RESET);

    always_comb begin
        next_count  = count;
        next_active = active;
        if (baud.load) begin
            next_count  = baud.reload_value;
            next_active = 1'b1;
        end else if (baud.expired) begin
            // Halts until the next phase reloads it
            next_active = 1'b0;
        end else if (active) begin
            next_count = count - 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count  <= BAUD_RESET;
            active <= 1'b0;
        end else begin
            count  <= next_count;
            active <= next_active;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/imba_core.sv ----
// I2C master sequencer with bus arbitration and collision detection.
// Assumes open-drain pins resolved outside; pins enter unsynchronised.
// Function
// - Shifting: released one read back as zero sets collision, goes idle.
// - Byte collision stops shifting, clears buffer full, releases both lines.
// - Sequence collision aborts it, releases lines, clears request bits.
// - After collision, a bus Stop sets the serial port interrupt flag.
// - Buffer write after collision starts from the first data bit.
// - Start with SDA or SCL low aborts, flags collision, goes idle.
// - Start: SDA high loads counter; SCL low with SDA high collides.
// - SDA low in first Start count restarts counter, drives SDA early.
// - SDA high through count: drive SDA low, count, then drive SCL.
// - Repeated Start: release SDA, count, release SCL, low SDA collides.
// - Repeated Start: SDA fall fine; SCL fall with SDA free collides.
// - Both high at timeout: drive SDA, count, then drive SCL low.
// - Stop: release SCL, when high count, release SDA; SDA low collides.
// - Stop: SCL low before SDA released is a collision.
// - Baud counter loads the reload value and starts on buffer write.
// - Finished operation halts the counter and holds the clock level.
// - Counter reloads once per clock phase, twice per period.
`timescale 1ns/100ps
`default_nettype none
module imba_core (
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe,
    input  wire logic                    scl_in,
    output logic                         scl_out,
    output logic                         scl_oe,
    input  wire logic [imba_pkg::BAUD_W-1:0] baud_reload_value,
    input  wire logic                    buf_write,
    input  wire logic [7:0]              buf_wdata,
    input  wire logic                    start_set,
    input  wire logic                    restart_set,
    input  wire logic                    stop_set,
    input  wire logic                    ack_set,
    input  wire logic                    ack_data,
    input  wire logic                    bcl_clear,
    input  wire logic                    irq_clear,
    output logic [imba_pkg::SEQ_W-1:0]   sequence_control_reg,
    output logic                         buffer_full_flag,
    output logic                         bus_collision_flag,
    output logic                         serial_port_irq_flag,
    output logic                         start_seen,
    output logic                         stop_seen,
    output logic                         ack_status,
    output logic                         busy
);
    import imba_pkg::*;

    imba_baud_if baud ();

    imba_baud_counter u_baud (
        .mclk   (mclk),
        .resetn (resetn),
        .baud   (baud.cnt)
    );

    // Pin synchronisers; only the second stage is read
    logic [SYNC_STAGES-1:0] sda_sync;
    logic [SYNC_STAGES-1:0] scl_sync;
    logic                   sda_s;
    logic                   scl_s;
    logic                   sda_prev;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sda_sync <= '1;
            scl_sync <= '1;
            sda_prev <= 1'b1;
        end else begin
            sda_sync <= {sda_sync[0], sda_in};
            scl_sync <= {scl_sync[0], scl_in};
            sda_prev <= sda_s;
        end
    end

    assign sda_s = sda_sync[SYNC_STAGES-1];
    assign scl_s = scl_sync[SYNC_STAGES-1];

    logic bus_start;
    logic bus_stop;
    assign bus_start = scl_s && sda_prev && !sda_s;
    assign bus_stop  = scl_s && !sda_prev && sda_s;

    imba_state_type    state;
    imba_state_type    next_state;
    logic              sda_low;
    logic              next_sda_low;
    logic              scl_low;
    logic              next_scl_low;
    logic [SEQ_W-1:0]  seq;
    logic [SEQ_W-1:0]  next_seq;
    logic [7:0]        shreg;
    logic [7:0]        next_shreg;
    logic [BIT_W-1:0]  bitcnt;
    logic [BIT_W-1:0]  next_bitcnt;
    logic              bf;
    logic              next_bf;
    logic              ackst;
    logic              next_ackst;
    logic              bcl;
    logic              next_bcl;
    logic              irq;
    logic              next_irq;
    logic              arb_lost;
    logic              next_arb_lost;
    logic              s_seen;
    logic              next_s_seen;
    logic              p_seen;
    logic              next_p_seen;
    logic              load;
    logic              coll;
    logic              done;

    assign baud.reload_value = baud_reload_value;
    assign baud.load         = load;

    always_comb begin
        next_state    = state;
        next_sda_low  = sda_low;
        next_scl_low  = scl_low;
        next_seq      = seq;
        next_shreg    = shreg;
        next_bitcnt   = bitcnt;
        next_bf       = bf;
        next_ackst    = ackst;
        next_arb_lost = arb_lost;
        load          = 1'b0;
        coll          = 1'b0;
        done          = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (seq[SEQ_START]) begin
                    if (!sda_s || !scl_s) begin
                        coll = 1'b1;
                    end else begin
                        load       = 1'b1;
                        next_state = ST_CNT1;
                    end
                end else if (seq[SEQ_RESTART]) begin
                    next_sda_low = 1'b0;
                    load         = 1'b1;
                    next_state   = RS_CNT0;
                end else if (seq[SEQ_STOP]) begin
                    next_sda_low = 1'b1;
                    next_state   = SP_WSDA;
                end else if (seq[SEQ_ACK]) begin
                    next_scl_low = 1'b1;
                    next_sda_low = !ack_data;
                    load         = 1'b1;
                    next_state   = AK_CNT0;
                end else if (buf_write) begin
                    // Always restart at the top bit
                    next_shreg  = buf_wdata;
                    next_bitcnt = BIT_FIRST;
                    next_bf     = 1'b1;
                    load        = 1'b1;
                    next_state  = TX_LOW;
                end
            end
            ST_CNT1: begin
                if (!sda_s) begin
                    // Another master started first: no collision
                    next_sda_low = 1'b1;
                    load         = 1'b1;
                    next_state   = ST_CNT2;
                end else if (!scl_s) begin
                    coll = 1'b1;
                end else if (baud.expired) begin
                    next_sda_low = 1'b1;
                    load         = 1'b1;
                    next_state   = ST_CNT2;
                end
            end
            ST_CNT2: begin
                // SCL low here is ignored
                if (baud.expired) begin
                    next_scl_low = 1'b1;
                    done         = 1'b1;
                end
            end
            RS_CNT0: begin
                if (baud.expired) begin
                    next_scl_low = 1'b0;
                    next_state   = RS_WSCL;
                end
            end
            RS_WSCL: begin
                if (scl_s) begin
                    if (!sda_s) begin
                        coll = 1'b1;
                    end else begin
                        load       = 1'b1;
                        next_state = RS_CNT1;
                    end
                end
            end
            RS_CNT1: begin
                if (!sda_s) begin
                    next_sda_low = 1'b1;
                    load         = 1'b1;
                    next_state   = RS_CNT2;
                end else if (!scl_s) begin
                    coll = 1'b1;
                end else if (baud.expired) begin
                    next_sda_low = 1'b1;
                    load         = 1'b1;
                    next_state   = RS_CNT2;
                end
            end
            RS_CNT2: begin
                if (baud.expired) begin
                    next_scl_low = 1'b1;
                    done         = 1'b1;
                end
            end
            SP_WSDA: begin
                if (!sda_s) begin
                    load       = 1'b1;
                    next_state = SP_CNT0;
                end
            end
            SP_CNT0: begin
                if (baud.expired) begin
                    next_scl_low = 1'b0;
                    next_state   = SP_WSCL;
                end
            end
            SP_WSCL: begin
                if (scl_s) begin
                    load       = 1'b1;
                    next_state = SP_CNT1;
                end
            end
            SP_CNT1: begin
                if (!scl_s) begin
                    coll = 1'b1;
                end else if (baud.expired) begin
                    next_sda_low = 1'b0;
                    load         = 1'b1;
                    next_state   = SP_CNT2;
                end
            end
            SP_CNT2: begin
                if (baud.expired) begin
                    if (!sda_s) begin
                        coll = 1'b1;
                    end else begin
                        done = 1'b1;
                    end
                end
            end
            AK_CNT0: begin
                if (baud.expired) begin
                    next_scl_low = 1'b0;
                    next_state   = AK_WSCL;
                end
            end
            AK_WSCL: begin
                if (scl_s) begin
                    load       = 1'b1;
                    next_state = AK_CNT1;
                end
            end
            AK_CNT1: begin
                if (!sda_low && !sda_s) begin
                    coll = 1'b1;
                end else if (baud.expired) begin
                    next_scl_low = 1'b1;
                    done         = 1'b1;
                end
            end
            TX_LOW: begin
                next_scl_low = 1'b1;
                next_sda_low = (bitcnt == BIT_ACK) ? 1'b0 : !shreg[7];
                if (baud.expired) begin
                    next_scl_low = 1'b0;
                    next_state   = TX_WSCL;
                end
            end
            TX_WSCL: begin
                if (scl_s) begin
                    load       = 1'b1;
                    next_state = TX_HIGH;
                end
            end
            TX_HIGH: begin
                if (bitcnt != BIT_ACK && !sda_low && !sda_s) begin
                    coll = 1'b1;
                end else if (baud.expired) begin
                    next_scl_low = 1'b1;
                    load         = 1'b1;
                    next_state   = TX_LOW;
                    if (bitcnt == BIT_ACK) begin
                        next_ackst  = sda_s;
                        next_bf     = 1'b0;
                        next_sda_low = 1'b0;
                        load        = 1'b0;
                        done        = 1'b1;
                    end else if (bitcnt == BIT_RESET) begin
                        next_bitcnt = BIT_ACK;
                    end else begin
                        next_shreg  = {shreg[6:0], 1'b0};
                        next_bitcnt = bitcnt - 4'h1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (done) begin
            // Clock pin keeps its last level once idle
            next_seq   = SEQ_RESET;
            next_state = ST_IDLE;
        end
        if (coll) begin
            next_state    = ST_IDLE;
            next_sda_low  = 1'b0;
            next_scl_low  = 1'b0;
            next_seq      = SEQ_RESET;
            next_bf       = 1'b0;
            next_bitcnt   = BIT_RESET;
            next_arb_lost = 1'b1;
        end else if (arb_lost && bus_stop) begin
            next_arb_lost = 1'b0;
        end
        if (state == ST_IDLE && !coll && next_state == ST_IDLE) begin
            next_seq = seq | {ack_set, stop_set, restart_set, start_set};
        end
        // Set beats clear on both sticky flags
        next_bcl = coll || (bcl && !bcl_clear);
        next_irq = done || (arb_lost && bus_stop)
                   || (irq && !irq_clear);
        next_s_seen = bus_start || (s_seen && !bus_stop);
        next_p_seen = bus_stop || (p_seen && !bus_start);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            sda_low  <= 1'b0;
            scl_low  <= 1'b0;
            seq      <= SEQ_RESET;
            shreg    <= BYTE_RESET;
            bitcnt   <= BIT_RESET;
            bf       <= 1'b0;
            ackst    <= 1'b0;
            bcl      <= 1'b0;
            irq      <= 1'b0;
            arb_lost <= 1'b0;
            s_seen   <= 1'b0;
            p_seen   <= 1'b0;
        end else begin
            state    <= next_state;
            sda_low  <= next_sda_low;
            scl_low  <= next_scl_low;
            seq      <= next_seq;
            shreg    <= next_shreg;
            bitcnt   <= next_bitcnt;
            bf       <= next_bf;
            ackst    <= next_ackst;
            bcl      <= next_bcl;
            irq      <= next_irq;
            arb_lost <= next_arb_lost;
            s_seen   <= next_s_seen;
            p_seen   <= next_p_seen;
        end
    end

    // Open drain: only ever pull low
    assign sda_out              = 1'b0;
    assign sda_oe               = sda_low;
    assign scl_out              = 1'b0;
    assign scl_oe               = scl_low;
    assign sequence_control_reg = seq;
    assign buffer_full_flag     = bf;
    assign bus_collision_flag   = bcl;
    assign serial_port_irq_flag = irq;
    assign start_seen           = s_seen;
    assign stop_seen            = p_seen;
    assign ack_status           = ackst;
    assign busy                 = (state != ST_IDLE) || (seq != SEQ_RESET);
endmodule
`default_nettype wire

// ---- bench/imba_core_monitor.sv ----
// Concurrent checks on the arbitration block's top-level ports.
// Assumes one clock domain and the bench's wired-AND bus.
`timescale 1ns/100ps
`default_nettype none
module imba_core_monitor (
    input wire logic                          mclk,
    input wire logic                          resetn,
    input wire logic                          sda_in,
    input wire logic                          scl_in,
    input wire logic                          sda_oe,
    input wire logic                          scl_oe,
    input wire logic [imba_pkg::BAUD_W-1:0]   baud_reload_value,
    input wire logic                          buf_write,
    input wire logic [7:0]                    buf_wdata,
    input wire logic                          start_set,
    input wire logic                          bcl_clear,
    input wire logic                          irq_clear,
    input wire logic [imba_pkg::SEQ_W-1:0]    sequence_control_reg,
    input wire logic                          buffer_full_flag,
    input wire logic                          bus_collision_flag,
    input wire logic                          serial_port_irq_flag,
    input wire logic                          busy
);
    import imba_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic [8:0] hold_cnt;
    logic [8:0] next_hold_cnt;
    // Cycles with SDA pulled and SCL still free
    always_comb begin
        next_hold_cnt = (sda_oe && !scl_oe) ? hold_cnt + 9'h001 : 9'h000;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt <= 9'h000;
        end else begin
            hold_cnt <= next_hold_cnt;
        end
    end
    sequence bus_stop_s;
        bus_collision_flag && scl_in && $rose(sda_in);
    endsequence
    sequence low_start_s;
        (!scl_in) [*4] ##0 (start_set && !busy);
    endsequence
    a_loss_releases: assert property (
        $rose(bus_collision_flag) |-> !sda_oe && !scl_oe &&
        !buffer_full_flag && sequence_control_reg == 4'h0)
        else $error("collision left a line or request held");
    a_bcl_sticks: assert property (
        bus_collision_flag && !bcl_clear |=> bus_collision_flag)
        else $error("collision flag dropped by itself");
    a_bcl_clears: assert property (
        bcl_clear && !busy && !start_set |=> !bus_collision_flag)
        else $error("collision flag ignored its clear");
    a_start_pin_low: assert property (
        low_start_s |-> ##[1:5]
        (bus_collision_flag && sequence_control_reg == 4'h0))
        else $error("start on a low clock line not aborted");
    a_start_hold: assert property (
        $rose(scl_oe) && $past(sequence_control_reg[SEQ_START]) |->
        hold_cnt == {1'b0, baud_reload_value} + 9'h001)
        else $error("start hold time is not one reload period");
    a_stop_irq: assert property (
        bus_stop_s ##1 (!irq_clear) [*6] |-> serial_port_irq_flag)
        else $error("bus stop after collision raised no interrupt");
    a_idle_hold: assert property (
        !busy ##1 !busy |-> $stable(sda_oe) && $stable(scl_oe))
        else $error("line moved while idle");
    a_first_bit: assert property (
        buf_write && !busy |=> buffer_full_flag ##1 (scl_oe &&
        sda_oe == !$past(buf_wdata[7], 2)))
        else $error("write did not start at the first data bit");
endmodule
bind imba_core imba_core_monitor mon (
    .mclk(mclk), .resetn(resetn), .sda_in(sda_in), .scl_in(scl_in),
    .sda_oe(sda_oe), .scl_oe(scl_oe),
    .baud_reload_value(baud_reload_value), .buf_write(buf_write),
    .buf_wdata(buf_wdata), .start_set(start_set), .bcl_clear(bcl_clear),
    .irq_clear(irq_clear), .sequence_control_reg(sequence_control_reg),
    .buffer_full_flag(buffer_full_flag),
    .bus_collision_flag(bus_collision_flag),
    .serial_port_irq_flag(serial_port_irq_flag), .busy(busy));
`default_nettype wire

// ---- bench/imba_bus_partner.sv ----
// Other masters and slaves on the shared bus, with the pull-ups.
// Assumes the bench calls its tasks to pull the lines.
`timescale 1ns/100ps
`default_nettype none
module imba_bus_partner (
    input  wire logic dut_sda_oe,
    input  wire logic dut_scl_oe,
    output logic      sda,
    output logic      scl
);
    logic pull_sda = 1'b0;
    logic pull_scl = 1'b0;
    // Released lines float high through the pull-ups
    assign sda = !(dut_sda_oe || pull_sda);
    assign scl = !(dut_scl_oe || pull_scl);
    task automatic hold(input logic s, input logic c);
        pull_sda = s;
        pull_scl = c;
    endtask
    // Winning master clocks on at its own 200 ns period
    task automatic ext_bits(input int n);
        repeat (n) begin
            pull_scl = 1'b1;
            #100;
            pull_scl = 1'b0;
            #100;
        end
    endtask
    // Frees the bus with a Stop so the host may start again
    task automatic ext_stop();
        pull_sda = 1'b1;
        pull_scl = 1'b1;
        #100;
        pull_scl = 1'b0;
        #100;
        pull_sda = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- bench/imba_tb_top.sv ----
// Self-checking bench for the arbitration block.
// Assumes the partner model resolves both open-drain lines.
`timescale 1ns/100ps
`default_nettype none
module imba_tb_top;
    import imba_pkg::*;
    // Smallest legal reload keeps the run short
    localparam logic [BAUD_W-1:0] BAUD = 8'h03;
    logic             mclk, resetn, sda, scl, sda_oe, scl_oe, bf, bcl;
    logic             buf_write, start_set, restart_set, stop_set;
    logic             ack_set, ack_data, bcl_clear, irq_clear, irq;
    logic             s_seen, p_seen, ack_st, busy, sda_o, scl_o;
    logic [7:0]       buf_wdata, st;
    logic [SEQ_W-1:0] seq;
    int               miscompares = 0;
    int               total_checks = 0;
    bit               exp_q[$];
    assign st = {seq, sda_oe, scl_oe, bcl, irq};
    imba_core dut (
        .mclk(mclk), .resetn(resetn), .sda_in(sda), .sda_out(sda_o),
        .sda_oe(sda_oe), .scl_in(scl), .scl_out(scl_o), .scl_oe(scl_oe),
        .baud_reload_value(BAUD), .buf_write(buf_write),
        .buf_wdata(buf_wdata), .start_set(start_set),
        .restart_set(restart_set), .stop_set(stop_set),
        .ack_set(ack_set), .ack_data(ack_data), .bcl_clear(bcl_clear),
        .irq_clear(irq_clear), .sequence_control_reg(seq),
        .buffer_full_flag(bf), .bus_collision_flag(bcl),
        .serial_port_irq_flag(irq), .start_seen(s_seen),
        .stop_seen(p_seen), .ack_status(ack_st), .busy(busy));
    imba_bus_partner bus (.dut_sda_oe(sda_oe), .dut_scl_oe(scl_oe),
        .sda(sda), .scl(scl));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic ran_out();
        miscompares++;
        $display("FAIL %0t wait ran out", $time);
        end_of_test();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic op(ref logic s);
        pulse(irq_clear);
        pulse(s);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) tick(1);
        if (busy !== 1'b0) ran_out();
    endtask
    task automatic wait_scl(input logic v);
        for (int i = 0; i < 400 && scl !== v; i++) tick(1);
        if (scl !== v) ran_out();
    endtask
    task automatic start_ok();
        pulse(bcl_clear);
        op(start_set);
        wait_idle();
        check(st, 8'h0D, "start");
    endtask
    task automatic send_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) exp_q.push_back(d[i]);
        buf_wdata = d;
        op(buf_write);
        for (int i = 0; i < 9; i++) begin
            wait_scl(1'b1);
            if (i < 8) check({7'h00, sda}, {7'h00, exp_q.pop_front()}, "bit");
            wait_scl(1'b0);
        end
        wait_idle();
        check({bf, ack_st, irq, 5'h00}, 8'h60, "byte end");
    endtask
    initial begin
        {buf_write, start_set, restart_set, stop_set, ack_set} = 5'h00;
        {ack_data, bcl_clear, irq_clear, resetn} = 4'h0;
        buf_wdata = 8'h00;
        void'($urandom(32'hA86C));
        repeat (3) @(posedge mclk);
        #2 resetn = 1'b1;
        tick(3);
        check({st[3:0], bf, busy, s_seen, p_seen}, 8'h00, "reset");
        start_ok();
        send_byte(8'($urandom));
        op(stop_set);
        wait_scl(1'b1);
        // Let the block see the released clock before stealing it
        tick(3);
        bus.hold(1'b0, 1'b1);
        wait_idle();
        check(st, 8'h02, "stop clock lost");
        bus.hold(1'b0, 1'b0);
        bus.ext_stop();
        tick(8);
        check({st[1:0], p_seen, 5'h00}, 8'hE0, "bus stop");
        pulse(bcl_clear);
        tick(1);
        check(st, 8'h01, "flag clear");
        for (int c = 0; c < 2; c++) begin
            pulse(bcl_clear);
            bus.hold(c == 0, c == 1);
            tick(4);
            op(start_set);
            wait_idle();
            check(st, 8'h02, "start on low line");
            bus.hold(1'b0, 1'b0);
            tick(8);
        end
        pulse(bcl_clear);
        op(start_set);
        bus.hold(1'b0, 1'b1);
        wait_idle();
        check(st, 8'h02, "clock low in start");
        bus.hold(1'b0, 1'b0);
        tick(8);
        start_ok();
        buf_wdata = 8'hFF;
        op(buf_write);
        bus.hold(1'b1, 1'b0);
        wait_idle();
        check(st, 8'h02, "data lost");
        check({5'h00, sda_o, scl_o, bf}, 8'h00, "released");
        bus.ext_bits(3);
        bus.ext_stop();
        tick(8);
        check(st, 8'h03, "stop after loss");
        start_ok();
        send_byte(8'h5A);
        op(restart_set);
        bus.hold(1'b1, 1'b0);
        wait_idle();
        check(st, 8'h02, "restart lost");
        bus.hold(1'b0, 1'b0);
        tick(8);
        start_ok();
        op(restart_set);
        wait_scl(1'b1);
        tick(3);
        bus.hold(1'b0, 1'b1);
        wait_idle();
        check(st, 8'h02, "restart clock lost");
        bus.hold(1'b0, 1'b0);
        tick(8);
        start_ok();
        send_byte(8'($urandom));
        op(restart_set);
        wait_idle();
        check(st, 8'h0D, "restart");
        ack_data = 1'b1;
        op(ack_set);
        wait_idle();
        check(st, 8'h05, "ack");
        op(stop_set);
        wait_idle();
        check(st, 8'h01, "stop");
        check({6'h00, s_seen, p_seen}, 8'h01, "stop seen");
        end_of_test();
    end
endmodule
`default_nettype wire
